// file: core/vectored_interrupt_map.sv
// vectored interrupt map: enable register, gating, ranking, vector out
// assumes pending flags come from logic on clk; core takes vector on irq_req
`timescale 1ns/10ps
module vectored_interrupt_map
    import irq_map_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic [7:0] sfr_addr,
    input wire logic sfr_wr,
    input wire logic [7:0] sfr_wdata,
    input wire logic sfr_rd,
    output logic [7:0] sfr_rdata,
    input wire logic [7:0] bit_addr,
    input wire logic bit_wr,
    input wire logic bit_wdata,
    input wire logic [NUM_SOURCES-1:0] src_pending,
    input timer_flags_type timer_two_flags,
    input timer_flags_type timer_three_flags,
    input timer_flags_type timer_four_flags,
    input timer_flags_type timer_five_flags,
    input wire logic conversion_done_flag,
    input wire logic [7:0] extended_enable_one,
    input wire logic [7:0] extended_enable_two,
    input wire logic [NUM_SOURCES-1:0] priority_low_bits,
    input wire logic [NUM_SOURCES-1:0] priority_high_bits,
    output logic irq_req,
    output logic [15:0] irq_vector,
    output logic [1:0] irq_level,
    output logic [SRC_IDX_W-1:0] irq_source,
    output logic global_irq_enable
);
    logic [7:0] interrupt_enable_mask_r;
    logic [7:0] ie_nxt;
    logic [7:0] rdata_r;
    irq_grant_type grant_r;
    irq_grant_type grant_nxt;
    logic [NUM_SOURCES-1:0] src_enable;
    logic [NUM_SOURCES-1:0] src_raw;
    logic [NUM_SOURCES-1:0] src_req;

    // timer request: high flag unless it came from a capture that is masked, or low flag when its enable is set
    function automatic logic timer_request(input timer_flags_type f);
        return (f.high_overflow_flag & (~f.high_from_capture | f.capture_flag_en))
            | (f.low_overflow_flag & f.low_flag_en);
    endfunction

    // vector for a source index
    function automatic logic [15:0] vector_of(input logic [SRC_IDX_W-1:0] idx);
        return VECTOR_BASE + (16'(idx) << 3);
    endfunction

    // register write decode, byte then bit access
    wire ie_byte_hit = sfr_wr && (sfr_addr == IE_ADDR);
    wire ie_bit_hit = bit_wr && (bit_addr[7:3] == IE_ADDR[7:3]);
    wire [2:0] ie_bit_sel = bit_addr[2:0];

    always_comb begin
        ie_nxt = interrupt_enable_mask_r;
        if (ie_byte_hit) begin
            ie_nxt = sfr_wdata;
        end else if (ie_bit_hit) begin
            ie_nxt[ie_bit_sel] = bit_wdata;
        end
    end

    // enable layout: ie bits 6..0, then extended one and two in order
    assign src_enable[IE_SRC_BITS-1:0] = interrupt_enable_mask_r[IE_SRC_BITS-1:0];
    assign src_enable[EXTENDED_ENABLE_ONE_SRC_BASE +: EXTENDED_ENABLE_ONE_SRC_BITS] = extended_enable_one[EXTENDED_ENABLE_ONE_SRC_BITS-1:0];
    assign src_enable[EXTENDED_ENABLE_TWO_SRC_BASE +: EXTENDED_ENABLE_TWO_SRC_BITS] = extended_enable_two[EXTENDED_ENABLE_TWO_SRC_BITS-1:0];

    // per-source raw request: generic flag, or the timer/converter terms
    genvar g;
    generate
        for (g = 0; g < NUM_SOURCES; g++) begin : g_raw
            if (g == SRC_TIMER_TWO) begin : g_t2
                assign src_raw[g] = timer_request(timer_two_flags);
            end else if (g == SRC_TIMER_THREE) begin : g_t3
                assign src_raw[g] = timer_request(timer_three_flags);
            end else if (g == SRC_TIMER_FOUR) begin : g_t4
                assign src_raw[g] = timer_request(timer_four_flags);
            end else if (g == SRC_TIMER_FIVE) begin : g_t5
                assign src_raw[g] = timer_request(timer_five_flags);
            end else if (g == SRC_CONVERSION_DONE) begin : g_adc
                assign src_raw[g] = conversion_done_flag;
            end else begin : g_gen
                assign src_raw[g] = src_pending[g];
            end
        end
    endgenerate

    assign global_irq_enable = interrupt_enable_mask_r[IE_GLOBAL_BIT];
    // level, not edge: a flag left set keeps asking
    assign src_req = src_raw & src_enable & {NUM_SOURCES{global_irq_enable}};

    // rank: highest level first, lowest index among equals
    always_comb begin
        logic [1:0] lvl;
        lvl = 2'd0;
        grant_nxt = '0;
        grant_nxt.vector = RESET_VECTOR;
        for (int i = 0; i < NUM_SOURCES; i++) begin
            lvl = {priority_high_bits[i], priority_low_bits[i]};
            if (src_req[i] && (!grant_nxt.valid || lvl > grant_nxt.level)) begin
                grant_nxt.valid = 1'b1;
                grant_nxt.level = lvl;
                grant_nxt.source = SRC_IDX_W'(i);
                grant_nxt.vector = vector_of(SRC_IDX_W'(i));
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            interrupt_enable_mask_r <= IE_RESET;
        end else begin
            interrupt_enable_mask_r <= ie_nxt;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rdata_r <= 8'h00;
        end else begin
            rdata_r <= (sfr_rd && sfr_addr == IE_ADDR) ? interrupt_enable_mask_r : 8'h00;
        end
    end

    // one detect cycle; reset parks the vector at zero, unmaskable
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            grant_r <= '0;
        end else begin
            grant_r <= grant_nxt;
        end
    end

    assign sfr_rdata = rdata_r;
    assign irq_req = grant_r.valid;
    assign irq_vector = grant_r.vector;
    assign irq_level = grant_r.level;
    assign irq_source = grant_r.source;
endmodule // vectored_interrupt_map

// file: core/irq_map_pkg.sv
// constants, layouts and types of the vectored interrupt map
// assumes one system clock and a byte-wide special-function-register port
// What this block does
// - each source has a fixed vector from 0x0003 to 0x009b, eight bytes apart
// - timer two goes to 0x002b, order 5, primary plus capture and low enables
// - timer three goes to 0x0073, order 14, enabled from extended enable one
// - timer four goes to 0x008b, order 17, enabled from extended enable two
// - timer five goes to 0x0093, order 18, enabled from extended enable two
// - conversion done goes to 0x0053, order 10, gated by its own enable and the global bit
// - eight-bit enable register, global bit 7, seven source enables below, reset 0
// - enable register sits at 0xa8 on every page and is bit-addressable
// - among equal priority, the lower vector order wins
// - with the global enable clear no request reaches the core
// - two priority bits per source give levels 0 to 3, 3 highest
// - requests are sampled and ranked every clock, one cycle to detect
package irq_map_pkg;
    localparam int NUM_SOURCES = 20;
    localparam int SRC_IDX_W = 5;
    localparam logic [7:0] IE_ADDR = 8'ha8;
    localparam logic [7:0] IE_RESET = 8'h00;
    localparam int IE_GLOBAL_BIT = 7;
    localparam int IE_SRC_BITS = 7;
    localparam int EXTENDED_ENABLE_ONE_SRC_BASE = 7;
    localparam int EXTENDED_ENABLE_ONE_SRC_BITS = 8;
    localparam int EXTENDED_ENABLE_TWO_SRC_BASE = 15;
    localparam int EXTENDED_ENABLE_TWO_SRC_BITS = 5;
    localparam logic [15:0] VECTOR_BASE = 16'h0003;
    localparam logic [15:0] VECTOR_STEP = 16'h0008;
    localparam logic [15:0] RESET_VECTOR = 16'h0000;
    localparam int SRC_TIMER_TWO = 5;
    localparam int SRC_CONVERSION_DONE = 10;
    localparam int SRC_TIMER_THREE = 14;
    localparam int SRC_TIMER_FOUR = 17;
    localparam int SRC_TIMER_FIVE = 18;
    localparam int DETECT_CYCLES = 1;
    localparam int CALL_CYCLES = 4;
    localparam int BEST_RESPONSE_CYCLES = DETECT_CYCLES + CALL_CYCLES;

    typedef struct packed {
        logic high_overflow_flag;
        logic high_from_capture;
        logic low_overflow_flag;
        logic capture_flag_en;
        logic low_flag_en;
    } timer_flags_type;

    typedef struct packed {
        logic valid;
        logic [1:0] level;
        logic [SRC_IDX_W-1:0] source;
        logic [15:0] vector;
    } irq_grant_type;
endpackage

// file: verification/irq_map_monitor.sv
// port assertions for the interrupt map
// bound to every map instance, one clock domain
`timescale 1ns/10ps
module irq_map_monitor (
    input logic clk,
    input logic rst,
    input logic [7:0] sfr_addr,
    input logic sfr_rd,
    input logic [7:0] sfr_rdata,
    input logic irq_req,
    input logic [15:0] irq_vector,
    input logic [4:0] irq_source,
    input logic global_irq_enable
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    property vec_of(logic [4:0] s, logic [15:0] v);
        irq_req && irq_source == s |-> irq_vector == v;
    endproperty
    gate_off_a: assert property (!global_irq_enable |=> !irq_req) else $error("masked request");
    vec_step_a: assert property (irq_req |-> irq_vector == 16'h0003 + 16'h0008 * irq_source) else $error("vector");
    tmr_two_a: assert property (vec_of(5'd5, 16'h002b)) else $error("timer two");
    tmr_three_a: assert property (vec_of(5'd14, 16'h0073)) else $error("timer three");
    tmr_four_a: assert property (vec_of(5'd17, 16'h008b)) else $error("timer four");
    tmr_five_a: assert property (vec_of(5'd18, 16'h0093)) else $error("timer five");
    conv_done_a: assert property (vec_of(5'd10, 16'h0053)) else $error("conversion");
    rd_miss_a: assert property (sfr_rd && sfr_addr != 8'ha8 |=> sfr_rdata == 8'h00) else $error("read");
    cover property (irq_req && irq_source == 5'd18);
    cover property (sfr_rd && sfr_addr == 8'ha8);
    cover property ($fell(irq_req));
endmodule // irq_map_monitor
bind vectored_interrupt_map irq_map_monitor u_mon(.clk(clk), .rst(rst), .sfr_addr(sfr_addr), .sfr_rd(sfr_rd),
    .sfr_rdata(sfr_rdata), .irq_req(irq_req), .irq_vector(irq_vector), .irq_source(irq_source),
    .global_irq_enable(global_irq_enable));

// file: verification/periph_model.sv
// peripheral pending flags, held until cleared
// assumes set and clear come from the bench on clk
`timescale 1ns/10ps
module periph_model (
    input logic clk,
    input logic rst,
    input logic [19:0] set_flags,
    input logic [19:0] clr_flags,
    output logic [19:0] pending
);
    always_ff @(posedge clk or posedge rst) begin
        if (rst) pending <= 20'h00000;
        else pending <= (pending | set_flags) & ~clr_flags;
    end
endmodule // periph_model

// file: verification/tb_top.sv
// random and corner bench for the interrupt map
// assumes periph_model and the bound monitor
`timescale 1ns/10ps
module tb_top;
    import irq_map_pkg::*;
    logic clk = 0, rst = 1, wr = 0, rd = 0, bw = 0, bv = 0, cd = 0, req, ga;
    logic [7:0] ad = 0, wd = 0, ba = 0, e1 = 0, e2 = 0, ie = 0, rdat;
    logic [19:0] st = 0, cl = 0, pd, pl = 0, ph = 0;
    logic [15:0] vec;
    logic [1:0] lv;
    logic [4:0] sr;
    timer_flags_type t2 = 0, t3 = 0, t4 = 0, t5 = 0;
    int n_fail = 0, n_tests = 0, seed = 32'hcffd;
    always #25 clk = ~clk;
    periph_model u_per(.clk(clk), .rst(rst), .set_flags(st), .clr_flags(cl), .pending(pd));
    vectored_interrupt_map u_dut(.clk(clk), .rst(rst), .sfr_addr(ad), .sfr_wr(wr), .sfr_wdata(wd), .sfr_rd(rd),
        .sfr_rdata(rdat), .bit_addr(ba), .bit_wr(bw), .bit_wdata(bv), .src_pending(pd), .timer_two_flags(t2),
        .timer_three_flags(t3), .timer_four_flags(t4), .timer_five_flags(t5), .conversion_done_flag(cd),
        .extended_enable_one(e1), .extended_enable_two(e2), .priority_low_bits(pl), .priority_high_bits(ph),
        .irq_req(req), .irq_vector(vec), .irq_level(lv), .irq_source(sr), .global_irq_enable(ga));
    function automatic logic tq(timer_flags_type f);
        return f.high_overflow_flag & (!f.high_from_capture | f.capture_flag_en) | f.low_overflow_flag & f.low_flag_en;
    endfunction
    // winning source index, -1 when nothing may be asked
    function automatic int win();
        logic [19:0] a;
        int b;
        b = -1;
        a = pd & {e2[4:0], e1, ie[6:0]};
        {a[18], a[17], a[14], a[10], a[5]} = {e2[3] & tq(t5), e2[2] & tq(t4), e1[7] & tq(t3), e1[3] & cd, ie[5] & tq(t2)};
        for (int i = 19; i >= 0; i--)
            if (a[i] && ie[7] && (b < 0 || {ph[i], pl[i]} >= {ph[b], pl[b]})) b = i;
        return b;
    endfunction
    function automatic logic [15:0] ev();
        int b;
        b = win();
        return b < 0 ? 16'h0000 : VECTOR_BASE + VECTOR_STEP * 16'(b);
    endfunction
    // expected level and source of the grant
    function automatic logic [6:0] ex();
        int b;
        b = win();
        return b < 0 ? 7'h00 : {ph[b], pl[b], 5'(b)};
    endfunction
    task automatic chk(logic [17:0] g, logic [17:0] e);
        n_tests++;
        if (g !== e) begin
            n_fail++;
            $display("ERROR %0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic put(logic bit_mode, logic [7:0] a, logic [7:0] d);
        @(posedge clk) #1;
        {ad, wd, ba, bv} = {a, d, 5'h15, a[2:0], d[0]};
        {wr, bw} = {!bit_mode, bit_mode};
        if (bit_mode) ie[a[2:0]] = d[0];
        else if (a == IE_ADDR) ie = d;
        @(posedge clk) #1;
        {wr, bw} = 2'b00;
    endtask
    task automatic get(logic [7:0] a, logic [7:0] e);
        @(posedge clk) #1;
        {ad, rd} = {a, 1'b1};
        @(posedge clk) #1;
        rd = 0;
        chk(18'(rdat), 18'(e));
    endtask
    task automatic step();
        @(posedge clk) #1;
        {st, cl} = 40'h0;
        @(posedge clk) #1;
        chk({req, ga, vec}, {ev() != 16'h0000, ie[7], ev()});
        chk(18'({lv, sr}), 18'(ex()));
    endtask
    task automatic close_out();
        $display("checks %0d fails %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial begin
        repeat (2) @(posedge clk);
        #1 rst = 0;
        put(0, 8'h55, 8'hff);
        get(IE_ADDR, IE_RESET);
        get(8'h55, 8'h00);
        for (int b = 0; b < 8; b++) put(1, 8'(b), 8'h01);
        get(IE_ADDR, 8'hff);
        put(1, 8'h07, 8'h00);
        st = 20'hfffff;
        step();
        for (int k = 0; k < 400; k++) begin
            if (k % 16 == 0) put(0, IE_ADDR, 8'($random(seed)));
            {e1, e2, t2, t3, t4, t5, cd} = 37'({$random(seed), $random(seed)});
            {pl, ph} = 40'({$random(seed), $random(seed)});
            st = 20'($random(seed) & $random(seed) & $random(seed));
            cl = 20'($random(seed) & $random(seed));
            step();
        end
        close_out();
    end
    initial begin
        #400000;
        n_fail++;
        close_out();
    end
endmodule // tb_top
